// *** include/pie_regs.svh ***
`ifndef PIE_REGS_SVH
`define PIE_REGS_SVH
// ============================================================
// sizes
`define PIE_NSRC        28
`define PIE_NCH         8
// ============================================================
// apb offsets
`define PIE_OFF_STAT    12'h000
`define PIE_OFF_CLR     12'h004
`define PIE_OFF_IEN     12'h008
`define PIE_OFF_EDGE    12'h00C
`define PIE_PAGE_SRC    4'h1
`define PIE_PAGE_CH     4'h2
`define PIE_CH_SRCPTR   2'h0
`define PIE_CH_DSTPTR   2'h1
`define PIE_CH_CFG      2'h2
// ============================================================
// field layout
`define PIE_SRC_W       10
`define PIE_CFG_W       11
`define PIE_EDGE_RISE   0
`define PIE_EDGE_FALL   1
// ============================================================
// reset values
`define PIE_SRC_RST     10'h000
`define PIE_CFG_RST     11'h000
`define PIE_PTR_RST     16'h0000
`define PIE_EDGE_RSTV   16'h0000
`define PIE_ST_RST      8'h00
// ============================================================
// trap numbers
`define PIE_TRAP_EXT    7'h18
`define PIE_TRAP_GPT    7'h22
`define PIE_TRAP_SER    7'h2A
`define PIE_TRAP_XP     7'h40
`define PIE_TRAP_TXB    7'h47
// ============================================================
// timing
`define PIE_CLK_MHZ     50
`define PIE_LAT_MIN_NS  250
`define PIE_LAT_MAX_NS  600
`define PIE_LAT_MIN_CYC ((`PIE_LAT_MIN_NS * `PIE_CLK_MHZ + 999) / 1000)
`define PIE_LAT_MAX_CYC ((`PIE_LAT_MAX_NS * `PIE_CLK_MHZ) / 1000)
`define PIE_PATH_CYC    4
`endif

// *** include/pie_pkg.sv ***
package pie_pkg;
  typedef enum logic [1:0] {SVC_IRQ, SVC_XFER, SVC_TRAP} pie_kind_e;

  typedef struct packed {
    logic [2:0] ch;
    logic       xfer;
    logic [3:0] lvl;
    logic       ie;
    logic       ir;
  } pie_src_s;

  typedef struct packed {
    logic       cont;
    logic       dinc;
    logic       word;
    logic [7:0] cnt;
  } pie_cfg_s;

  typedef struct packed {
    pie_cfg_s    cfg;
    logic [15:0] dst;
    logic [15:0] src;
  } pie_ch_s;

  typedef struct packed {
    pie_kind_e   kind;
    logic [8:0]  vec;
    logic [3:0]  lvl;
    logic [15:0] src;
    logic [15:0] dst;
    logic        word;
  } pie_svc_s;
endpackage

// *** rtl/pie_ctrl.sv ***
`timescale 1ns/1ps
`include "pie_regs.svh"

// Contract
// - each source owns flag, enable, priority register
// - priority field picks one of sixteen levels
// - serve only above current core priority
// - standard service branches core to source vector
// - vector is four times trap number
// - source to trap number map as listed
// - software routes source to interrupt or transfer
// - transfer steals exactly one core cycle
// - move byte or word, bump one pointer
// - counter decrements unless continuous mode
// - counter zero turns request into interrupt
// - eight independent transfer channels
// - external inputs detect rising, falling, both
// - software can set node request flags
// - trap instruction vectors by its number
// - response latency 250ns to 600ns
module pie_ctrl (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [11:0]        paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [7:0]         ext_pin,
  input  wire logic [15:0]        periph_evt,
  input  wire logic               txbuf_evt,
  input  wire logic               trap_req,
  input  wire logic [6:0]         trap_num,
  input  wire logic [3:0]         cpu_lvl,
  input  wire logic               svc_ack,
  output logic                    svc_req,
  output pie_pkg::pie_svc_s       svc,
  output logic                    irq
);
  localparam int NSRC = `PIE_NSRC;
  localparam int NCH  = `PIE_NCH;

  // ==========================================================
  // trap number lookup
  function automatic logic [6:0] trap_of(input logic [4:0] idx);
    logic [6:0] t;
    t = 7'h00;
    if (idx < 5'h08)
      t = `PIE_TRAP_EXT + {2'h0, idx};
    else if (idx < 5'h0E)
      t = `PIE_TRAP_GPT + {2'h0, idx - 5'h08};
    else if (idx < 5'h14)
      t = `PIE_TRAP_SER + {2'h0, idx - 5'h0E};
    else if (idx < 5'h1B)
      t = `PIE_TRAP_XP + {2'h0, idx - 5'h14};
    else
      t = `PIE_TRAP_TXB;
    return t;
  endfunction

  // ==========================================================
  // address step of one transfer
  function automatic logic [15:0] ptr_step(input logic word);
    return word ? 16'h0002 : 16'h0001;
  endfunction

  // ==========================================================
  // state
  pie_pkg::pie_src_s src_ff [NSRC];
  pie_pkg::pie_src_s nxt_src [NSRC];
  pie_pkg::pie_ch_s  ch_ff [NCH];
  pie_pkg::pie_ch_s  nxt_ch [NCH];
  pie_pkg::pie_svc_s svc_ff;
  pie_pkg::pie_svc_s nxt_svc;
  logic [7:0]        st_ff;
  logic [7:0]        ien_ff;
  logic [15:0]       edge_ff;
  logic [7:0]        s1_ff;
  logic [7:0]        s2_ff;
  logic [7:0]        s3_ff;
  logic              trap_pend_ff;
  logic [6:0]        trap_num_ff;
  logic              req_ff;
  logic              nxt_req;
  logic [4:0]        win_ff;
  logic [4:0]        nxt_win;
  logic [31:0]       prdata_ff;
  logic [7:0]        ch_zero;

  // ==========================================================
  // apb decode
  wire        apb_wr   = psel & penable & pwrite;
  wire        apb_set  = psel & ~penable;
  wire [3:0]  page     = paddr[11:8];
  wire [4:0]  src_idx  = paddr[6:2];
  wire [2:0]  ch_idx   = paddr[6:4];
  wire [1:0]  ch_sub   = paddr[3:2];
  wire        sub_sptr = ch_sub == `PIE_CH_SRCPTR;
  wire        sub_dptr = ch_sub == `PIE_CH_DSTPTR;
  wire        hit_stat = paddr == `PIE_OFF_STAT;
  wire        hit_clr  = paddr == `PIE_OFF_CLR;
  wire        hit_ien  = paddr == `PIE_OFF_IEN;
  wire        hit_edge = paddr == `PIE_OFF_EDGE;
  wire        hit_src  = page == `PIE_PAGE_SRC && paddr[7] == 1'b0
                         && paddr[1:0] == 2'h0 && src_idx < 5'(NSRC);
  wire        hit_ch   = page == `PIE_PAGE_CH && paddr[7] == 1'b0
                         && paddr[1:0] == 2'h0 && ch_sub != 2'h3;
  wire        hit      = hit_stat | hit_clr | hit_ien | hit_edge | hit_src | hit_ch;
  wire [7:0]  clr_mask = (apb_wr && hit_clr) ? pwdata[7:0] : 8'h00;

  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata  = prdata_ff;

  logic [31:0] rd_val;
  always_comb begin
    rd_val = 32'h0000_0000;
    if (hit_stat)
      rd_val = {24'h00_0000, st_ff};
    else if (hit_ien)
      rd_val = {24'h00_0000, ien_ff};
    else if (hit_edge)
      rd_val = {16'h0000, edge_ff};
    else if (hit_src)
      rd_val = {22'h0, src_ff[src_idx]};
    else if (hit_ch && sub_sptr)
      rd_val = {16'h0000, ch_ff[ch_idx].src};
    else if (hit_ch && sub_dptr)
      rd_val = {16'h0000, ch_ff[ch_idx].dst};
    else if (hit_ch)
      rd_val = {21'h0, ch_ff[ch_idx].cfg};
  end

  // ==========================================================
  // external edge detect
  wire [7:0]  rise     = s2_ff & ~s3_ff;
  wire [7:0]  fall     = ~s2_ff & s3_ff;
  logic [7:0] ext_edge;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ext_edge[i] = (edge_ff[2*i + `PIE_EDGE_RISE] & rise[i])
                  | (edge_ff[2*i + `PIE_EDGE_FALL] & fall[i]);
    end
  end

  // software nodes 24..26 have no hardware event
  wire [27:0] hw_set = {txbuf_evt, 3'h0, periph_evt, ext_edge};

  // ==========================================================
  // arbitration
  logic       found;
  logic [4:0] best;
  logic [3:0] best_lvl;
  always_comb begin
    found    = 1'b0;
    best     = 5'h00;
    best_lvl = 4'h0;
    // ascending index equals ascending trap number
    for (int i = 0; i < NSRC; i++) begin
      if (src_ff[i].ir && src_ff[i].ie && (!found || src_ff[i].lvl > best_lvl)) begin
        found    = 1'b1;
        best     = 5'(i);
        best_lvl = src_ff[i].lvl;
      end
    end
  end

  wire                    win_ok  = found && best_lvl > cpu_lvl;
  wire pie_pkg::pie_src_s win_src = src_ff[best];
  wire pie_pkg::pie_ch_s  win_ch  = ch_ff[win_src.ch];
  wire                    win_xfr = win_src.xfer
                                    && (win_ch.cfg.cont || win_ch.cfg.cnt != 8'h00);
  wire                    accept  = req_ff & svc_ack;
  wire                    acc_xfr = accept && svc_ff.kind == pie_pkg::SVC_XFER;
  wire                    acc_src = accept && svc_ff.kind != pie_pkg::SVC_TRAP;
  wire [2:0]              acc_ch  = src_ff[win_ff].ch;

  // ==========================================================
  // service request to core
  always_comb begin
    nxt_req = req_ff & ~svc_ack;
    nxt_svc = svc_ff;
    nxt_win = win_ff;
    if (!req_ff) begin
      if (trap_pend_ff) begin
        nxt_req      = 1'b1;
        nxt_svc      = '0;
        nxt_svc.kind = pie_pkg::SVC_TRAP;
        nxt_svc.vec  = {trap_num_ff, 2'h0};
        nxt_svc.lvl  = cpu_lvl;
      end else if (win_ok) begin
        nxt_req      = 1'b1;
        nxt_win      = best;
        nxt_svc.kind = win_xfr ? pie_pkg::SVC_XFER : pie_pkg::SVC_IRQ;
        nxt_svc.vec  = {trap_of(best), 2'h0};
        nxt_svc.lvl  = best_lvl;
        nxt_svc.src  = win_ch.src;
        nxt_svc.dst  = win_ch.dst;
        nxt_svc.word = win_ch.cfg.word;
      end
    end
  end

  assign svc_req = req_ff;
  assign svc     = svc_ff;
  assign irq     = |(st_ff & ien_ff);

  // ==========================================================
  // source control registers
  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      nxt_src[i] = src_ff[i];
      if (apb_wr && hit_src && src_idx == 5'(i))
        nxt_src[i] = pie_pkg::pie_src_s'(pwdata[`PIE_SRC_W-1:0]);
      if (acc_src && win_ff == 5'(i))
        nxt_src[i].ir = 1'b0;
      if (hw_set[i])
        nxt_src[i].ir = 1'b1;
    end
  end

  // ==========================================================
  // transfer channels
  always_comb begin
    ch_zero = 8'h00;
    for (int c = 0; c < NCH; c++) begin
      nxt_ch[c] = ch_ff[c];
      if (apb_wr && hit_ch && ch_idx == 3'(c)) begin
        if (sub_sptr)
          nxt_ch[c].src = pwdata[15:0];
        else if (sub_dptr)
          nxt_ch[c].dst = pwdata[15:0];
        else
          nxt_ch[c].cfg = pie_pkg::pie_cfg_s'(pwdata[`PIE_CFG_W-1:0]);
      end
      // one accept cycle is the only cycle taken from the core
      if (acc_xfr && acc_ch == 3'(c)) begin
        if (ch_ff[c].cfg.dinc)
          nxt_ch[c].dst = ch_ff[c].dst + ptr_step(ch_ff[c].cfg.word);
        else
          nxt_ch[c].src = ch_ff[c].src + ptr_step(ch_ff[c].cfg.word);
        if (!ch_ff[c].cfg.cont) begin
          nxt_ch[c].cfg.cnt = ch_ff[c].cfg.cnt - 8'h01;
          ch_zero[c]        = ch_ff[c].cfg.cnt == 8'h01;
        end
      end
    end
  end

  // ==========================================================
  // flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NSRC; i++)
        src_ff[i] <= pie_pkg::pie_src_s'(`PIE_SRC_RST);
    end else begin
      src_ff <= nxt_src;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int c = 0; c < NCH; c++)
        ch_ff[c] <= {pie_pkg::pie_cfg_s'(`PIE_CFG_RST), `PIE_PTR_RST, `PIE_PTR_RST};
    end else begin
      ch_ff <= nxt_ch;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_ff <= 1'b0;
      svc_ff <= '0;
      win_ff <= 5'h00;
    end else begin
      req_ff <= nxt_req;
      svc_ff <= nxt_svc;
      win_ff <= nxt_win;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trap_pend_ff <= 1'b0;
      trap_num_ff  <= 7'h00;
    end else if (trap_req && !trap_pend_ff) begin
      trap_pend_ff <= 1'b1;
      trap_num_ff  <= trap_num;
    end else if (accept && svc_ff.kind == pie_pkg::SVC_TRAP) begin
      trap_pend_ff <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_ff <= 8'h00;
      s2_ff <= 8'h00;
      s3_ff <= 8'h00;
    end else begin
      s1_ff <= ext_pin;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // ==========================================================
  // status, enable and edge configuration
  // set beats clear when both land on one edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= `PIE_ST_RST;
    end else begin
      st_ff <= (st_ff & ~clr_mask) | ch_zero;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ien_ff  <= `PIE_ST_RST;
      edge_ff <= `PIE_EDGE_RSTV;
    end else begin
      if (apb_wr && hit_ien)
        ien_ff <= pwdata[7:0];
      if (apb_wr && hit_edge)
        edge_ff <= pwdata[15:0];
    end
  end

  // ==========================================================
  // read data, captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
    end else if (apb_set && !pwrite) begin
      prdata_ff <= rd_val;
    end
  end
endmodule

// *** dv/pie_chk.sv ***
`timescale 1ns/1ps
module pie_chk (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [3:0]        cpu_lvl,
  input wire logic              svc_ack,
  input wire logic              svc_req,
  input wire pie_pkg::pie_svc_s svc
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_const_a: assert property (pready) else $error("pready low");
  slverr_phase_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
  req_hold_a: assert property (svc_req && !svc_ack |=> svc_req && $stable(svc))
    else $error("offer changed before accept");
  req_drop_a: assert property (svc_req && svc_ack |=> !svc_req)
    else $error("offer kept after accept");
  lvl_above_a: assert property ($rose(svc_req) && svc.kind != pie_pkg::SVC_TRAP
    |-> svc.lvl > $past(cpu_lvl)) else $error("offer not above core level");
  trap_lvl_a: assert property ($rose(svc_req) && svc.kind == pie_pkg::SVC_TRAP
    |-> svc.lvl == $past(cpu_lvl)) else $error("trap level wrong");
  vec_align_a: assert property (svc_req |-> svc.vec[1:0] == 2'h0)
    else $error("vector not word aligned");
  vec_range_a: assert property (svc_req && svc.kind == pie_pkg::SVC_IRQ |-> svc.vec inside
    {[9'h060:9'h07C], [9'h088:9'h09C], [9'h0A8:9'h0BC], [9'h100:9'h11C]})
    else $error("vector outside map");
  kind_legal_a: assert property (svc_req |-> svc.kind != 2'h3)
    else $error("illegal service kind");
endmodule

bind pie_ctrl pie_chk i_pie_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
  .cpu_lvl, .svc_ack, .svc_req, .svc);

// *** dv/pie_core_mdl.sv ***
`timescale 1ns/1ps
// ==========
// core side: raises ack dly+1 cycles after each offer appears
module pie_core_mdl (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              svc_req,
  input  wire pie_pkg::pie_svc_s svc,
  input  wire logic [3:0]        dly,
  output logic                   ack_ff,
  output logic                   taken_ff,
  output pie_pkg::pie_svc_s      got_ff
);
  logic [3:0] cnt_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_ff   <= 4'h0;
      ack_ff   <= 1'b0;
      taken_ff <= 1'b0;
      got_ff   <= '0;
    end else begin
      taken_ff <= svc_req && ack_ff;
      if (svc_req && ack_ff) begin
        got_ff <= svc;
      end
      ack_ff <= 1'b0;
      if (svc_req && !ack_ff) begin
        ack_ff <= (cnt_ff == dly);
        cnt_ff <= (cnt_ff == dly) ? 4'h0 : cnt_ff + 4'h1;
      end
    end
  end
endmodule

// *** dv/pie_ctrl_tb.sv ***
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin n_fail++; \
  $display("unexpected %s exp %0h got %0h", n, e, g); end end
module pie_ctrl_tb;
  logic              pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0]       paddr = 12'h000;
  logic [31:0]       pwdata = 32'h0, prdata, rd;
  logic              pready, pslverr, err, svc_ack, svc_req, irq, taken;
  logic              txbuf_evt = 0, trap_req = 0;
  logic [7:0]        ext_pin = 8'h00;
  logic [15:0]       periph_evt = 16'h0000;
  logic [6:0]        trap_num = 7'h00;
  logic [3:0]        cpu_lvl = 4'h0, dly = 4'h0;
  pie_pkg::pie_svc_s svc, got;
  int                n_fail = 0, n_checks = 0, n_tk = 0, n0;
  time               t0;
  always #10 pclk = ~pclk;
  always @(posedge pclk) if (taken) n_tk++;
  pie_ctrl i_pie_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .ext_pin, .periph_evt, .txbuf_evt, .trap_req, .trap_num, .cpu_lvl,
    .svc_ack, .svc_req, .svc, .irq);
  pie_core_mdl i_pie_core_mdl (.pclk, .presetn, .svc_req, .svc, .dly, .ack_ff(svc_ack),
    .taken_ff(taken), .got_ff(got));
  function automatic logic [8:0] vec_of(input int i);
    return {7'(i + (i < 8 ? 8'h18 : i < 14 ? 8'h1A : i < 20 ? 8'h1C : 8'h2C)), 2'h0};
  endfunction
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task src(input int i, input logic [9:0] v);
    apb(1'b1, 12'h100 + 12'(4 * i), {22'h0, v});
  endtask
  task wait_tk(input int n);
    repeat (60) if (n_tk < n) @(posedge pclk);
    `CHK("served", n, n_tk)
  endtask
  task pulse(input logic [15:0] m, input logic t);
    @(posedge pclk);
    periph_evt <= m;
    txbuf_evt <= t;
    @(posedge pclk);
    periph_evt <= 16'h0000;
    txbuf_evt <= 1'b0;
  endtask
  task t_regs;
    apb(1'b0, 12'h100, 32'h0);
    `CHK("src rst", 32'h0, rd)
    src(8, 10'h3FC);
    apb(1'b0, 12'h120, 32'h0);
    `CHK("src rw", 32'h3FC, rd)
    src(8, 10'h000);
    apb(1'b0, 12'h20C, 32'h0);
    `CHK("unmapped", 1'b1, err)
  endtask
  task t_irq;
    cpu_lvl <= 4'h2;
    for (int k = 0; k < 16; k++) begin
      src(8 + k, 10'h016);
      t0 = $time;
      pulse(16'h0001 << k, 1'b0);
      wait_tk(n_tk + 1);
      `CHK("lat", 1'b1, ($time - t0) <= 600)
      `CHK("vec", vec_of(8 + k), got.vec)
      `CHK("kind", pie_pkg::SVC_IRQ, got.kind)
      apb(1'b0, 12'h120 + 12'(4 * k), 32'h0);
      `CHK("flag", 1'b0, rd[0])
      src(8 + k, 10'h000);
    end
  endtask
  task t_prio;
    dly <= 4'h4;
    src(9, 10'h016);
    src(10, 10'h016);
    src(11, 10'h026);
    pulse(16'h000E, 1'b0);
    for (int j = 0; j < 3; j++) begin
      wait_tk(n_tk + 1);
      `CHK("order", vec_of(j == 0 ? 11 : 8 + j), got.vec)
    end
    cpu_lvl <= 4'h5;
    pulse(16'h0002, 1'b0);
    repeat (10) @(posedge pclk);
    `CHK("held", 1'b0, svc_req)
    cpu_lvl <= 4'h4;
    wait_tk(n_tk + 1);
    dly <= 4'h0;
  endtask
  task t_ext;
    apb(1'b1, 12'h00C, 32'h39);
    for (int p = 0; p < 3; p++) begin
      src(p, 10'h016);
      n0 = n_tk;
      ext_pin[p] <= 1'b1;
      repeat (12) @(posedge pclk);
      `CHK("rise", (p != 1) ? 1 : 0, n_tk - n0)
      n0 = n_tk;
      ext_pin[p] <= 1'b0;
      repeat (12) @(posedge pclk);
      `CHK("fall", (p != 0) ? 1 : 0, n_tk - n0)
    end
  endtask
  task t_xfer;
    cpu_lvl <= 4'h2;
    apb(1'b1, 12'h230, 32'h1000);
    apb(1'b1, 12'h234, 32'h2000);
    apb(1'b1, 12'h238, 32'h102);
    apb(1'b1, 12'h008, 32'h08);
    src(27, 10'h1D2);
    for (int j = 0; j < 3; j++) begin
      pulse(16'h0000, 1'b1);
      wait_tk(n_tk + 1);
      `CHK("kind", j < 2 ? pie_pkg::SVC_XFER : pie_pkg::SVC_IRQ, got.kind)
      if (j < 2) `CHK("sptr", 16'(16'h1000 + 2 * j), got.src)
      if (j < 2) `CHK("word", 1'b1, got.word)
    end
    `CHK("vec", 9'h11C, got.vec)
    `CHK("irq", 1'b1, irq)
    apb(1'b1, 12'h008, 32'h00);
    @(posedge pclk);
    `CHK("mask", 1'b0, irq)
    apb(1'b1, 12'h008, 32'h08);
    apb(1'b1, 12'h004, 32'h08);
    @(posedge pclk);
    `CHK("clr", 1'b0, irq)
    apb(1'b1, 12'h274, 32'h3000);
    apb(1'b1, 12'h278, 32'h605);
    src(27, 10'h3D2);
    repeat (2) begin
      pulse(16'h0000, 1'b1);
      wait_tk(n_tk + 1);
    end
    `CHK("dptr", 16'h3001, got.dst)
    `CHK("byte", 1'b0, got.word)
    apb(1'b0, 12'h278, 32'h0);
    `CHK("cont", 32'h605, rd)
    apb(1'b0, 12'h238, 32'h0);
    `CHK("chan3", 32'h100, rd)
  endtask
  task t_trap;
    cpu_lvl <= 4'h7;
    trap_num <= 7'h0A;
    pulse(16'h0000, 1'b0);
    trap_req <= 1'b1;
    @(posedge pclk);
    trap_req <= 1'b0;
    wait_tk(n_tk + 1);
    `CHK("trap", 9'h028, got.vec)
    src(24, 10'h027);
    wait_tk(n_tk + 1);
    `CHK("node", 9'h110, got.vec)
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_irq;
    t_prio;
    t_ext;
    t_xfer;
    t_trap;
    test_done;
  end
  initial begin
    #400000;
    n_fail++;
    test_done;
  end
endmodule
